// File: verilog/ldcfg_pkg.sv
package ldcfg_pkg;

	localparam int NUM_LDN = 8;

	// logical device numbers
	localparam logic [7:0] LDN_FLOPPY   = 8'h00;
	localparam logic [7:0] LDN_PARALLEL = 8'h03;
	localparam logic [7:0] LDN_SERIAL1  = 8'h04;
	localparam logic [7:0] LDN_SERIAL2  = 8'h05;
	localparam logic [7:0] LDN_RTC      = 8'h06;
	localparam logic [7:0] LDN_KBD      = 8'h07;

	// slot indices
	localparam logic [7:0] SLOT_ACTIVATE = 8'h30;
	localparam logic [7:0] SLOT_BASE_HI  = 8'h60;
	localparam logic [7:0] SLOT_BASE_LO  = 8'h61;
	localparam logic [7:0] SLOT_IR_HI    = 8'h62;
	localparam logic [7:0] SLOT_IR_LO    = 8'h63;
	localparam logic [7:0] SLOT_IRQ      = 8'h70;
	localparam logic [7:0] SLOT_DMA      = 8'h74;
	localparam logic [7:0] RUN_SLOT_LO   = 8'h82;
	localparam logic [7:0] RUN_SLOT_HI   = 8'h9A;

	// field positions and widths
	localparam int ACT_BIT   = 0;
	localparam int IRQ_W     = 4;
	localparam int DMA_W     = 3;
	localparam int DMA_NONE_BIT = 2;

	// relocatable base limits
	localparam logic [15:0] BASE_MIN    = 16'h0100;
	localparam logic [15:0] BASE_MAX8   = 16'h0FF8;
	localparam logic [15:0] BASE_MAX4   = 16'h0FFC;

	// fixed ports
	localparam logic [15:0] RTC_ADDR0   = 16'h0070;
	localparam logic [15:0] RTC_DATA    = 16'h0071;
	localparam logic [15:0] RTC_ADDR1   = 16'h0074;
	localparam logic [15:0] KBD_DATA    = 16'h0060;
	localparam logic [15:0] KBD_CMD     = 16'h0064;

	// values after reset
	localparam logic [7:0]       RST_BYTE = 8'h00;
	localparam logic [IRQ_W-1:0] RST_IRQ  = 4'h0;
	localparam logic [DMA_W-1:0] RST_DMA  = 3'h4;

	typedef struct packed {
		logic        strobe;
		logic [15:0] addr;
	} isa_req_s;

endpackage : ldcfg_pkg

// File: verilog/logical_device_config_bank.sv
`timescale 1ns/100ps

module logical_device_config_bank (
	input  wire logic               I_REF_CLK,
	input  wire logic               I_NRST,
	input  wire logic               I_CONFIG_STATE,
	input  wire logic [7:0]         I_LDN_SELECT,
	input  wire logic               I_INDEX_WR,
	input  wire logic               I_DATA_WR,
	input  wire logic               I_DATA_RD,
	input  wire logic [7:0]         I_WDATA,
	input  wire ldcfg_pkg::isa_req_s I_ISA,
	output logic      [7:0]         O_RDATA,
	output logic                    O_RDATA_VALID,
	output logic      [7:0]         O_DEV_ACTIVE,
	output logic      [7:0]         O_DEV_HIT,
	output logic                    O_IR_HIT,
	output logic                    O_ZERO_WAIT_STATE_N,
	output logic                    O_EPP_ENABLE,
	output logic      [31:0]        O_IRQ_LEVEL,
	output logic      [23:0]        O_DMA_CHAN,
	output logic      [7:0]         O_DMA_VALID
);

	typedef struct packed {
		logic [7:0]                            index;
		logic [7:0]                            active;
		logic [7:0][7:0]                       base_hi;
		logic [7:0][7:0]                       base_lo;
		logic [7:0]                            ir_hi;
		logic [7:0]                            ir_lo;
		logic [7:0][ldcfg_pkg::IRQ_W-1:0]      irq;
		logic [7:0][ldcfg_pkg::DMA_W-1:0]      dma;
		logic [7:0]                            rdata;
		logic                                  rdata_valid;
		logic [7:0]                            hit;
		logic                                  ir_hit;
		logic                                  zws_n;
		logic                                  epp;
		logic [7:0]                            dma_valid;
	} bank_state_s;

	bank_state_s state;
	bank_state_s next_state;

	function automatic logic ldn_reserved(input logic [7:0] ldn);
		ldn_reserved = (ldn == 8'h01) || (ldn == 8'h02) || (ldn > 8'h07);
	endfunction : ldn_reserved

	function automatic logic has_dma(input logic [7:0] ldn);
		has_dma = (ldn == ldcfg_pkg::LDN_FLOPPY) ||
			(ldn == ldcfg_pkg::LDN_PARALLEL);
	endfunction : has_dma

	function automatic logic base_ok8(input logic [15:0] b);
		base_ok8 = (b >= ldcfg_pkg::BASE_MIN) &&
			(b <= ldcfg_pkg::BASE_MAX8) && (b[2:0] == 3'h0);
	endfunction : base_ok8

	// thirteen-bit compare (address bits 15..3) of an 8-byte window
	function automatic logic hit8(input logic [15:0] a, input logic [15:0] b);
		hit8 = base_ok8(b) && (a[15:3] == b[15:3]);
	endfunction : hit8

	function automatic logic [7:0] slot_read(input bank_state_s s,
		input logic [2:0] ldn);
		logic [7:0] v;
		v = 8'h00;
		case (s.index)
			ldcfg_pkg::SLOT_ACTIVATE: begin
				v = {7'h00, s.active[ldn]};
			end
			ldcfg_pkg::SLOT_BASE_HI: begin
				v = s.base_hi[ldn];
			end
			ldcfg_pkg::SLOT_BASE_LO: begin
				v = s.base_lo[ldn];
			end
			ldcfg_pkg::SLOT_IR_HI: begin
				if ({5'h00, ldn} == ldcfg_pkg::LDN_SERIAL2) begin
					v = s.ir_hi;
				end
			end
			ldcfg_pkg::SLOT_IR_LO: begin
				if ({5'h00, ldn} == ldcfg_pkg::LDN_SERIAL2) begin
					v = s.ir_lo;
				end
			end
			ldcfg_pkg::SLOT_IRQ: begin
				v = {4'h0, s.irq[ldn]};
			end
			ldcfg_pkg::SLOT_DMA: begin
				if (has_dma({5'h00, ldn})) begin
					v = {5'h00, s.dma[ldn]};
				end
			end
			// every other slot is unimplemented and reads zero
			default: begin
				v = 8'h00;
			end
		endcase
		slot_read = v;
	endfunction : slot_read

	logic [2:0]  ldn;
	logic        reserved;
	logic        run_window;
	logic        access_ok;
	logic [15:0] par_base;
	logic [15:0] dev_base;
	logic [15:0] ir_base;
	logic [15:0] epp_base;
	logic        par_hit;
	logic        rtc_hit;
	logic        kbd_hit;
	logic        any_hit;

	always_comb begin
		ldn        = I_LDN_SELECT[2:0];
		reserved   = ldn_reserved(I_LDN_SELECT);
		run_window = (I_LDN_SELECT == ldcfg_pkg::LDN_KBD) &&
			(state.index >= ldcfg_pkg::RUN_SLOT_LO) &&
			(state.index <= ldcfg_pkg::RUN_SLOT_HI);
		access_ok  = !reserved &&
			(I_CONFIG_STATE || run_window);

		next_state             = state;
		next_state.rdata_valid = 1'b0;

		// index write selects the slot for later data accesses
		if (I_INDEX_WR) begin
			next_state.index = I_WDATA;
		end

		if (I_DATA_WR && access_ok) begin
			case (state.index)
				ldcfg_pkg::SLOT_ACTIVATE: begin
					// reserved upper bits are simply not stored
					next_state.active[ldn] =
						I_WDATA[ldcfg_pkg::ACT_BIT];
				end
				ldcfg_pkg::SLOT_BASE_HI: begin
					next_state.base_hi[ldn] = I_WDATA;
				end
				ldcfg_pkg::SLOT_BASE_LO: begin
					next_state.base_lo[ldn] = I_WDATA;
				end
				ldcfg_pkg::SLOT_IR_HI: begin
					if (I_LDN_SELECT == ldcfg_pkg::LDN_SERIAL2) begin
						next_state.ir_hi = I_WDATA;
					end
				end
				ldcfg_pkg::SLOT_IR_LO: begin
					if (I_LDN_SELECT == ldcfg_pkg::LDN_SERIAL2) begin
						next_state.ir_lo = I_WDATA;
					end
				end
				ldcfg_pkg::SLOT_IRQ: begin
					next_state.irq[ldn] =
						I_WDATA[ldcfg_pkg::IRQ_W-1:0];
				end
				ldcfg_pkg::SLOT_DMA: begin
					if (has_dma(I_LDN_SELECT)) begin
						next_state.dma[ldn] =
							I_WDATA[ldcfg_pkg::DMA_W-1:0];
					end
				end
				default: begin
					next_state.index = next_state.index;
				end
			endcase
		end

		// a refused read still answers, with zero
		if (I_DATA_RD) begin
			next_state.rdata_valid = 1'b1;
			next_state.rdata = access_ok ?
				slot_read(state, ldn) : 8'h00;
		end

		// channel codes 4..7 leave the device without DMA
		// taken from the next field so valid moves with the channel
		for (int i = 0; i < ldcfg_pkg::NUM_LDN; i++) begin
			next_state.dma_valid[i] = has_dma(8'(i)) &&
				!next_state.dma[i][ldcfg_pkg::DMA_NONE_BIT];
		end

		// isa decode, registered so outputs come from flops
		par_base = {state.base_hi[ldcfg_pkg::LDN_PARALLEL[2:0]],
			state.base_lo[ldcfg_pkg::LDN_PARALLEL[2:0]]};
		ir_base  = {state.ir_hi, state.ir_lo};
		next_state.hit = 8'h00;
		for (int i = 0; i < ldcfg_pkg::NUM_LDN; i++) begin
			dev_base = {state.base_hi[i], state.base_lo[i]};
			if (i == 0 || i == 4 || i == 5) begin
				next_state.hit[i] = I_ISA.strobe && state.active[i] &&
					hit8(I_ISA.addr, dev_base);
			end
		end

		// a 4-aligned parallel base only spans four ports
		if (par_base[2]) begin
			par_hit = (par_base >= ldcfg_pkg::BASE_MIN) &&
				(par_base <= ldcfg_pkg::BASE_MAX4) &&
				(I_ISA.addr[15:2] == par_base[15:2]);
		end else begin
			par_hit = hit8(I_ISA.addr, par_base);
		end
		next_state.hit[ldcfg_pkg::LDN_PARALLEL[2:0]] = I_ISA.strobe &&
			state.active[ldcfg_pkg::LDN_PARALLEL[2:0]] && par_hit;
		// mode flag follows the written base in the same edge as active
		epp_base = {next_state.base_hi[ldcfg_pkg::LDN_PARALLEL[2:0]],
			next_state.base_lo[ldcfg_pkg::LDN_PARALLEL[2:0]]};
		next_state.epp = next_state.active[ldcfg_pkg::LDN_PARALLEL[2:0]] &&
			base_ok8(epp_base);

		rtc_hit = (I_ISA.addr == ldcfg_pkg::RTC_ADDR0) ||
			(I_ISA.addr == ldcfg_pkg::RTC_DATA) ||
			(I_ISA.addr == ldcfg_pkg::RTC_ADDR1);
		kbd_hit = (I_ISA.addr == ldcfg_pkg::KBD_DATA) ||
			(I_ISA.addr == ldcfg_pkg::KBD_CMD);
		next_state.hit[ldcfg_pkg::LDN_RTC[2:0]] = I_ISA.strobe &&
			state.active[ldcfg_pkg::LDN_RTC[2:0]] && rtc_hit;
		next_state.hit[ldcfg_pkg::LDN_KBD[2:0]] = I_ISA.strobe &&
			state.active[ldcfg_pkg::LDN_KBD[2:0]] && kbd_hit;

		next_state.ir_hit = I_ISA.strobe &&
			state.active[ldcfg_pkg::LDN_SERIAL2[2:0]] &&
			hit8(I_ISA.addr, ir_base);

		any_hit = (next_state.hit != 8'h00) || next_state.ir_hit;
		// clock data port needs the slow cycle of the cmos array
		next_state.zws_n = !(any_hit &&
			!(next_state.hit[ldcfg_pkg::LDN_RTC[2:0]] &&
			(I_ISA.addr == ldcfg_pkg::RTC_DATA)));
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state.index       <= ldcfg_pkg::RST_BYTE;
			state.active      <= ldcfg_pkg::RST_BYTE;
			state.base_hi     <= '0;
			state.base_lo     <= '0;
			state.ir_hi       <= ldcfg_pkg::RST_BYTE;
			state.ir_lo       <= ldcfg_pkg::RST_BYTE;
			state.irq         <= {8{ldcfg_pkg::RST_IRQ}};
			state.dma         <= {8{ldcfg_pkg::RST_DMA}};
			state.rdata       <= ldcfg_pkg::RST_BYTE;
			state.rdata_valid <= 1'b0;
			state.hit         <= 8'h00;
			state.ir_hit      <= 1'b0;
			state.zws_n       <= 1'b1;
			state.epp         <= 1'b0;
			state.dma_valid   <= 8'h00;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		O_RDATA             = state.rdata;
		O_RDATA_VALID       = state.rdata_valid;
		O_DEV_ACTIVE        = state.active;
		O_DEV_HIT           = state.hit;
		O_IR_HIT            = state.ir_hit;
		O_ZERO_WAIT_STATE_N = state.zws_n;
		O_EPP_ENABLE        = state.epp;
		O_IRQ_LEVEL         = state.irq;
		O_DMA_CHAN          = state.dma;
		O_DMA_VALID         = state.dma_valid;
	end

endmodule : logical_device_config_bank

// File: verification/ldcfg_props.sv
`timescale 1ns/100ps
module ldcfg_props (
	input wire logic                I_REF_CLK,
	input wire logic                I_NRST,
	input wire logic                I_CONFIG_STATE,
	input wire logic [7:0]          I_LDN_SELECT,
	input wire logic                I_INDEX_WR,
	input wire logic                I_DATA_WR,
	input wire logic                I_DATA_RD,
	input wire logic [7:0]          I_WDATA,
	input wire ldcfg_pkg::isa_req_s I_ISA,
	input wire logic [7:0]          O_RDATA,
	input wire logic                O_RDATA_VALID,
	input wire logic [7:0]          O_DEV_ACTIVE,
	input wire logic [7:0]          O_DEV_HIT,
	input wire logic                O_IR_HIT,
	input wire logic                O_ZERO_WAIT_STATE_N,
	input wire logic                O_EPP_ENABLE,
	input wire logic [31:0]         O_IRQ_LEVEL,
	input wire logic [23:0]         O_DMA_CHAN,
	input wire logic [7:0]          O_DMA_VALID
);
	logic rsv_ldn;
	assign rsv_ldn = I_LDN_SELECT inside {8'h01, 8'h02} || I_LDN_SELECT > 8'h07;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);
	sequence s_read_answer;
		##1 O_RDATA_VALID;
	endsequence
	a_read_answer:
	assert property (I_DATA_RD |-> s_read_answer) else $error("read not answered");
	a_valid_only_read:
	assert property (!I_DATA_RD |=> !O_RDATA_VALID) else $error("stray valid");
	a_reserved_ldn_zero:
	assert property (I_DATA_RD && rsv_ldn |=> O_RDATA == 8'h00)
		else $error("reserved device read not zero");
	a_run_state_zero:
	assert property (I_DATA_RD && !I_CONFIG_STATE && I_LDN_SELECT != 8'h07
		|=> O_RDATA == 8'h00) else $error("run state read not zero");
	a_clock_data_wait:
	assert property (I_ISA.strobe && I_ISA.addr == ldcfg_pkg::RTC_DATA
		|=> O_ZERO_WAIT_STATE_N) else $error("no wait on clock data");
	a_hit_zero_wait:
	assert property ((O_DEV_HIT != 8'h00 || O_IR_HIT)
		&& $past(I_ISA.addr) != ldcfg_pkg::RTC_DATA |-> !O_ZERO_WAIT_STATE_N)
		else $error("hit without zero wait");
	a_idle_no_hit:
	assert property (!I_ISA.strobe |=> O_DEV_HIT == 8'h00 && !O_IR_HIT
		&& O_ZERO_WAIT_STATE_N) else $error("hit without cycle");
	a_inactive_no_hit:
	assert property ((O_DEV_HIT & ~$past(O_DEV_ACTIVE)) == 8'h00)
		else $error("inactive device hit");
	a_clock_fixed_port:
	assert property (I_ISA.strobe && I_ISA.addr == 16'h0070 && O_DEV_ACTIVE[6]
		|=> O_DEV_HIT[6]) else $error("clock port missed");
	a_kbd_fixed_port:
	assert property (I_ISA.strobe && I_ISA.addr == 16'h0064 && O_DEV_ACTIVE[7]
		|=> O_DEV_HIT[7]) else $error("keyboard port missed");
	a_dma_slot_owner:
	assert property ((O_DMA_VALID & 8'hF6) == 8'h00) else $error("dma slot");
	a_dma_none_code:
	assert property (O_DMA_VALID[0] == !O_DMA_CHAN[2]) else $error("dma code");
	a_epp_needs_active:
	assert property (O_EPP_ENABLE |-> O_DEV_ACTIVE[3]) else $error("epp idle");
endmodule : ldcfg_props

bind logical_device_config_bank ldcfg_props ldcfg_props_i (
	.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_CONFIG_STATE(I_CONFIG_STATE),
	.I_LDN_SELECT(I_LDN_SELECT), .I_INDEX_WR(I_INDEX_WR),
	.I_DATA_WR(I_DATA_WR), .I_DATA_RD(I_DATA_RD), .I_WDATA(I_WDATA),
	.I_ISA(I_ISA), .O_RDATA(O_RDATA), .O_RDATA_VALID(O_RDATA_VALID),
	.O_DEV_ACTIVE(O_DEV_ACTIVE), .O_DEV_HIT(O_DEV_HIT), .O_IR_HIT(O_IR_HIT),
	.O_ZERO_WAIT_STATE_N(O_ZERO_WAIT_STATE_N), .O_EPP_ENABLE(O_EPP_ENABLE),
	.O_IRQ_LEVEL(O_IRQ_LEVEL), .O_DMA_CHAN(O_DMA_CHAN),
	.O_DMA_VALID(O_DMA_VALID));

// File: verification/isa_host_model.sv
`timescale 1ns/100ps
module isa_host_model (
	input  wire logic          i_clk,
	input  wire logic [7:0]    i_rdata,
	input  wire logic          i_valid,
	output logic               o_cfg,
	output logic [7:0]         o_ldn,
	output logic               o_idx_wr,
	output logic               o_data_wr,
	output logic               o_data_rd,
	output logic [7:0]         o_wdata,
	output ldcfg_pkg::isa_req_s o_isa
);
	initial begin
		{o_cfg, o_ldn, o_idx_wr, o_data_wr, o_data_rd, o_wdata} = '0;
		o_isa = '0;
	end
	task automatic sel(input logic [7:0] l, input logic c);
		o_ldn = l;
		o_cfg = c;
	endtask : sel
	// index first, data port next cycle
	task automatic index(input logic [7:0] idx);
		o_idx_wr = 1'b1;
		o_wdata = idx;
		@(posedge i_clk);
		#1 o_idx_wr = 1'b0;
		o_wdata = ~idx;
	endtask : index
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		index(idx);
		o_data_wr = 1'b1;
		o_wdata = d;
		@(posedge i_clk);
		#1 o_data_wr = 1'b0;
		o_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		index(idx);
		o_data_rd = 1'b1;
		@(posedge i_clk);
		#1 o_data_rd = 1'b0;
		d = i_valid ? i_rdata : 8'hXX;
	endtask : rd
	// released bus shows inverted address, never the old one
	task automatic isa(input logic [15:0] a);
		o_isa = '{strobe: 1'b1, addr: a};
		@(posedge i_clk);
		#1 o_isa = '{strobe: 1'b0, addr: ~a};
	endtask : isa
endmodule : isa_host_model

// File: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic I_REF_CLK, I_NRST, cfg, iw, dw, dr, irh, nows, epp, vld;
	logic [7:0] ldn, wd, rdat, act, hit, dmav;
	logic [31:0] irq;
	logic [23:0] dma;
	ldcfg_pkg::isa_req_s isa;
	int err_total = 0;
	int tests_run = 0;
	logic [7:0] rsv [11] = '{8'h31, 8'h37, 8'h38, 8'h40, 8'h5F, 8'h62,
		8'h64, 8'h71, 8'h75, 8'h76, 8'hDF};
	logical_device_config_bank logical_device_config_bank_i (
		.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_CONFIG_STATE(cfg),
		.I_LDN_SELECT(ldn), .I_INDEX_WR(iw), .I_DATA_WR(dw), .I_DATA_RD(dr),
		.I_WDATA(wd), .I_ISA(isa), .O_RDATA(rdat), .O_RDATA_VALID(vld),
		.O_DEV_ACTIVE(act), .O_DEV_HIT(hit), .O_IR_HIT(irh),
		.O_ZERO_WAIT_STATE_N(nows), .O_EPP_ENABLE(epp), .O_IRQ_LEVEL(irq),
		.O_DMA_CHAN(dma), .O_DMA_VALID(dmav));
	isa_host_model isa_host_model_i (.i_clk(I_REF_CLK), .i_rdata(rdat),
		.i_valid(vld), .o_cfg(cfg), .o_ldn(ldn), .o_idx_wr(iw),
		.o_data_wr(dw), .o_data_rd(dr), .o_wdata(wd), .o_isa(isa));
	initial begin
		I_REF_CLK = 1'b0;
		forever #50 I_REF_CLK = ~I_REF_CLK;
	end
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		isa_host_model_i.rd(idx, d);
		chk("read data", {24'h0, exp}, {24'h0, d});
	endtask : rdchk
	task automatic cyc(input logic [15:0] a, input logic [7:0] h,
			input logic n);
		isa_host_model_i.isa(a);
		chk("hit", {24'h0, h}, {24'h0, hit});
		chk("zero wait", {31'h0, n}, {31'h0, nows});
	endtask : cyc
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge I_REF_CLK);
		err_total++;
		finish_test();
	end
	initial begin
		I_NRST = 1'b0;
		repeat (5) @(posedge I_REF_CLK);
		#1 I_NRST = 1'b1;
		chk("dma reset", 32'h924924, {8'h0, dma});
		isa_host_model_i.sel(8'h00, 1'b1);
		isa_host_model_i.wr(8'h30, 8'h01);
		chk("active", 32'h1, {24'h0, act});
		rdchk(8'h30, 8'h01);
		isa_host_model_i.wr(8'h70, 8'hFF);
		rdchk(8'h70, 8'h0F);
		isa_host_model_i.wr(8'h74, 8'h02);
		chk("dma chan", 32'h2, {29'h0, dma[2:0]});
		chk("dma valid", 32'h1, {31'h0, dmav[0]});
		foreach (rsv[i]) begin
			isa_host_model_i.wr(rsv[i], 8'hFF);
			rdchk(rsv[i], 8'h00);
		end
		$display("test floppy bank done");
		isa_host_model_i.sel(8'h04, 1'b1);
		isa_host_model_i.wr(8'h60, 8'h03);
		isa_host_model_i.wr(8'h61, 8'hF8);
		isa_host_model_i.wr(8'h74, 8'h01);
		rdchk(8'h74, 8'h00);
		isa_host_model_i.wr(8'h30, 8'h01);
		cyc(16'h03FF, 8'h10, 1'b0);
		cyc(16'h13F8, 8'h00, 1'b1);
		isa_host_model_i.sel(8'h03, 1'b1);
		isa_host_model_i.wr(8'h60, 8'h01);
		isa_host_model_i.wr(8'h61, 8'h04);
		isa_host_model_i.wr(8'h30, 8'h01);
		chk("epp off", 32'h0, {31'h0, epp});
		cyc(16'h0107, 8'h08, 1'b0);
		cyc(16'h0108, 8'h00, 1'b1);
		isa_host_model_i.wr(8'h61, 8'h08);
		chk("epp on", 32'h1, {31'h0, epp});
		isa_host_model_i.sel(8'h05, 1'b1);
		isa_host_model_i.wr(8'h62, 8'h02);
		isa_host_model_i.wr(8'h63, 8'hE8);
		isa_host_model_i.wr(8'h30, 8'h01);
		isa_host_model_i.isa(16'h02EC);
		chk("ir hit", 32'h1, {31'h0, irh});
		$display("test base decode done");
		isa_host_model_i.sel(8'h06, 1'b1);
		isa_host_model_i.wr(8'h60, 8'hAA);
		rdchk(8'h60, 8'hAA);
		isa_host_model_i.wr(8'h70, 8'h05);
		chk("irq level", 32'h5, {28'h0, irq[27:24]});
		isa_host_model_i.wr(8'h30, 8'h01);
		cyc(16'h0071, 8'h40, 1'b1);
		cyc(16'h0074, 8'h40, 1'b0);
		isa_host_model_i.sel(8'h07, 1'b1);
		isa_host_model_i.wr(8'h30, 8'h01);
		cyc(16'h0064, 8'h80, 1'b0);
		isa_host_model_i.sel(8'h00, 1'b0);
		isa_host_model_i.wr(8'h30, 8'h00);
		chk("run write", 32'h1, {31'h0, act[0]});
		rdchk(8'h30, 8'h00);
		isa_host_model_i.sel(8'h01, 1'b1);
		isa_host_model_i.wr(8'h60, 8'h12);
		rdchk(8'h60, 8'h00);
		$display("test fixed and state done");
		finish_test();
	end
endmodule : testbench
